/* File: rtl/clgt_pkg.sv */
// package for the clock generator control slice: register map, fields, resets
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register
`default_nettype none
package clgt_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_SRC_CTRL = 8'h00;
   localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFF_TRIM = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_LOOP_CTRL = 8'h10;
   localparam int ADDR_W = 8;

   // ****************************************
   // field positions
   // ****************************************
   localparam int SRC_HI = 7;
   localparam int SRC_LO = 6;
   localparam int DIV_HI = 7;
   localparam int DIV_LO = 6;
   localparam int RANGE_BIT = 5;
   localparam int GAIN_BIT = 4;
   localparam int LOWPWR_BIT = 3;
   localparam int EREF_SEL_BIT = 2;
   localparam int EREF_OE_BIT = 1;
   localparam int EREF_KEEP_BIT = 0;
   localparam int LOL_BIT = 7;
   localparam int LOCK_BIT = 6;
   localparam int FINE_BIT = 0;
   localparam int LOL_IE_BIT = 7;

   // ****************************************
   // reset values and codes
   // ****************************************
   localparam logic [7:0] CTRL_TWO_RST = 8'h40;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [7:0] SRC_CTRL_RST = 8'h00;
   localparam logic [1:0] SRC_LOOP = 2'h0;
   localparam logic [1:0] SRC_RESERVED = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] DIV_ONE = 4'h1;
endpackage
`default_nettype wire

/* File: rtl/clgt_lock_watch.sv */
// lock watcher: flags a loss of lock once lock had been acquired
// assumes lock detector outputs are synchronous to aclk
`default_nettype none
module clgt_lock_watch
   import clgt_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // lock detector
   input wire logic detect_en,
   input wire logic locked,
   // event
   output logic loss_pulse
);
   logic acquired_reg;
   logic acquired_next;
   logic loss_reg;
   logic loss_next;

   always_comb begin
      acquired_next = acquired_reg;
      loss_next = 1'b0;
      if (!detect_en) begin
         acquired_next = 1'b0;
      end else if (locked) begin
         acquired_next = 1'b1;
      end else if (acquired_reg) begin
         // lock had been acquired and is now lost
         loss_next = 1'b1;
         acquired_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acquired_reg <= 1'b0;
         loss_reg <= 1'b0;
      end else if (ce) begin
         acquired_reg <= acquired_next;
         loss_reg <= loss_next;
      end
   end

   assign loss_pulse = loss_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_loss_needs_lock;
      ce && detect_en && !locked && acquired_reg |=> loss_pulse;
   endproperty
   a_loss_needs_lock: assert property (p_loss_needs_lock)
      else $error("lock loss not flagged");

   property p_no_loss_when_off;
      ce && !detect_en |=> !loss_pulse;
   endproperty
   a_no_loss_when_off: assert property (p_no_loss_when_off)
      else $error("loss flagged with detection off");
endmodule
`default_nettype wire

/* File: rtl/clgt_ctrl.sv */
// clock generator control slice: three documented registers plus source and
// loop control, behind an AXI4-Lite slave
// assumes all inputs synchronous to aclk; ce low freezes all state
// Contract
// - bus divider bits 7:6 divide 1/2/4/8, reset 2
// - bit 5 selects high or low range
// - bit 4 high gain or low power oscillator
// - bit 3 stops loop in bypassed modes
// - bit 2 crystal or direct external clock
// - bit 1 gates external reference clock output
// - bit 0 keeps external reference in stop
// - eight trim bits, binary weighted period adjust
// - larger trim lengthens internal reference period
// - sticky loss-of-lock flag set after lock lost
// - flag cleared by reset or writing one
// - interrupt enable decides request on flag set
// - source select 00 loop, 01 internal, 10 external
// - interrupt enable bit 7 of loop register
`default_nettype none
module clgt_ctrl
   import clgt_pkg::*;
(
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // generator state
   input wire logic lock_detect_en,
   input wire logic loop_locked,
   input wire logic stop_mode,
   input wire logic bypass_mode,
   input wire logic ext_ref_mode,
   // controls
   output logic [1:0] clock_source_select,
   output logic [3:0] bus_div_factor,
   output logic high_range,
   output logic osc_high_gain,
   output logic ext_ref_source_sel,
   output logic loop_enable,
   output logic ext_ref_clock_out_en,
   output logic ext_ref_run,
   output logic [8:0] irc_period_trim,
   output logic lol_irq
);
   // ****************************************
   // state
   // ****************************************
   logic [7:0] src_ctrl_reg, src_ctrl_next;
   logic [7:0] ctrl_two_reg, ctrl_two_next;
   logic [7:0] trim_reg, trim_next;
   logic fine_reg, fine_next;
   logic lol_flag_reg, lol_flag_next;
   logic lol_ie_reg, lol_ie_next;
   logic pre_stop_reg, pre_stop_next;
   logic aw_full_reg, aw_full_next;
   logic w_full_reg, w_full_next;
   logic [ADDR_W-1:0] waddr_reg, waddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic wstrb0_reg, wstrb0_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [1:0] src_out_reg, src_out_next;
   logic [3:0] div_reg, div_next;
   logic loop_en_reg, loop_en_next;
   logic eref_oe_reg, eref_oe_next;
   logic eref_run_reg, eref_run_next;
   logic irq_reg, irq_next;
   logic loss_pulse;
   logic wr_fire;
   logic wr_hit;

   clgt_lock_watch u_lock_watch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .detect_en(lock_detect_en),
      .locked(loop_locked),
      .loss_pulse(loss_pulse)
   );

   // ****************************************
   // bus slave and register file
   // ****************************************
   assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_hit = (waddr_reg == OFF_SRC_CTRL) || (waddr_reg == OFF_CTRL_TWO) ||
                   (waddr_reg == OFF_TRIM) || (waddr_reg == OFF_STATUS) ||
                   (waddr_reg == OFF_LOOP_CTRL);

   always_comb begin
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wstrb0_next = wstrb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      src_ctrl_next = src_ctrl_reg;
      ctrl_two_next = ctrl_two_reg;
      trim_next = trim_reg;
      fine_next = fine_reg;
      lol_ie_next = lol_ie_reg;
      lol_flag_next = lol_flag_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         waddr_next = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && wready_reg) begin
         w_full_next = 1'b1;
         wdata_next = s_axi_wdata[7:0];
         wstrb0_next = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) bvalid_next = 1'b0;
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (wstrb0_reg) begin
            case (waddr_reg)
               OFF_SRC_CTRL: src_ctrl_next = {wdata_reg[SRC_HI:SRC_LO], 6'h00};
               OFF_CTRL_TWO: ctrl_two_next = wdata_reg;
               OFF_TRIM: trim_next = wdata_reg;
               OFF_STATUS: begin
                  fine_next = wdata_reg[FINE_BIT];
                  if (wdata_reg[LOL_BIT]) lol_flag_next = 1'b0;
               end
               OFF_LOOP_CTRL: lol_ie_next = wdata_reg[LOL_IE_BIT];
               default: ;
            endcase
         end
      end
      // a loss in the clearing cycle still sets the flag
      if (loss_pulse) lol_flag_next = 1'b1;
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_rvalid && s_axi_rready) rvalid_next = 1'b0;
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = 32'h0000_0000;
         case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            OFF_SRC_CTRL: rdata_next[7:0] = src_ctrl_reg;
            OFF_CTRL_TWO: rdata_next[7:0] = ctrl_two_reg;
            OFF_TRIM: rdata_next[7:0] = trim_reg;
            OFF_STATUS: begin
               rdata_next[LOL_BIT] = lol_flag_reg;
               rdata_next[LOCK_BIT] = loop_locked;
               rdata_next[FINE_BIT] = fine_reg;
            end
            OFF_LOOP_CTRL: rdata_next[LOL_IE_BIT] = lol_ie_reg;
            default: rresp_next = RESP_SLVERR;
         endcase
      end
      arready_next = !rvalid_next;
   end

   // ****************************************
   // derived controls
   // ****************************************
   always_comb begin
      awready_next = !aw_full_next && !bvalid_next;
      wready_next = !w_full_next && !bvalid_next;
      pre_stop_next = pre_stop_reg;
      if (!stop_mode) pre_stop_next = ctrl_two_next[EREF_OE_BIT] || ext_ref_mode;
      // reserved code falls back to the loop output
      src_out_next = (src_ctrl_next[SRC_HI:SRC_LO] == SRC_RESERVED) ?
                     SRC_LOOP : src_ctrl_next[SRC_HI:SRC_LO];
      div_next = DIV_ONE << ctrl_two_next[DIV_HI:DIV_LO];
      loop_en_next = !(bypass_mode && ctrl_two_next[LOWPWR_BIT]);
      // output gate, off in stop unless kept
      eref_oe_next = ctrl_two_next[EREF_OE_BIT] &&
                     (!stop_mode || ctrl_two_next[EREF_KEEP_BIT]);
      eref_run_next = stop_mode ? (ctrl_two_next[EREF_KEEP_BIT] && pre_stop_reg) :
                      (ctrl_two_next[EREF_OE_BIT] || ext_ref_mode);
      irq_next = lol_flag_next && lol_ie_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_ctrl_reg <= SRC_CTRL_RST;
         ctrl_two_reg <= CTRL_TWO_RST;
         trim_reg <= TRIM_RST;
         fine_reg <= 1'b0;
         lol_flag_reg <= 1'b0;
         lol_ie_reg <= 1'b0;
         pre_stop_reg <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         waddr_reg <= OFF_SRC_CTRL;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
         src_out_reg <= SRC_LOOP;
         div_reg <= DIV_ONE << CTRL_TWO_RST[DIV_HI:DIV_LO];
         loop_en_reg <= 1'b1;
         eref_oe_reg <= 1'b0;
         eref_run_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (ce) begin
         src_ctrl_reg <= src_ctrl_next;
         ctrl_two_reg <= ctrl_two_next;
         trim_reg <= trim_next;
         fine_reg <= fine_next;
         lol_flag_reg <= lol_flag_next;
         lol_ie_reg <= lol_ie_next;
         pre_stop_reg <= pre_stop_next;
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wstrb0_reg <= wstrb0_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         src_out_reg <= src_out_next;
         div_reg <= div_next;
         loop_en_reg <= loop_en_next;
         eref_oe_reg <= eref_oe_next;
         eref_run_reg <= eref_run_next;
         irq_reg <= irq_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign clock_source_select = src_out_reg;
   assign bus_div_factor = div_reg;
   assign high_range = ctrl_two_reg[RANGE_BIT];
   assign osc_high_gain = ctrl_two_reg[GAIN_BIT];
   assign ext_ref_source_sel = ctrl_two_reg[EREF_SEL_BIT];
   assign loop_enable = loop_en_reg;
   assign ext_ref_clock_out_en = eref_oe_reg;
   assign ext_ref_run = eref_run_reg;
   // trim above fine bit: larger code, longer period
   assign irc_period_trim = {trim_reg, fine_reg};
   assign lol_irq = irq_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_div_map;
      bus_div_factor == (DIV_ONE << ctrl_two_reg[DIV_HI:DIV_LO]);
   endproperty
   a_div_map: assert property (p_div_map) else $error("bus divider factor mismatch");
   property p_div_reset;
      $rose(aresetn) |-> ctrl_two_reg[DIV_HI:DIV_LO] == 2'h1 && bus_div_factor == 4'h2;
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("divider not two after reset");
   property p_src_map;
      clock_source_select != SRC_RESERVED;
   endproperty
   a_src_map: assert property (p_src_map) else $error("reserved clock source driven");
   property p_loop_off;
      ce && bypass_mode && ctrl_two_reg[LOWPWR_BIT] && !wr_fire |=> !loop_enable;
   endproperty
   a_loop_off: assert property (p_loop_off) else $error("loop left on in bypass");
   property p_stop_off;
      ce && stop_mode && !ctrl_two_next[EREF_KEEP_BIT] |=> !ext_ref_run && !ext_ref_clock_out_en;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("ext reference on in stop");
   property p_lol_set;
      ce && loss_pulse |=> lol_flag_reg && lol_irq == lol_ie_reg;
   endproperty
   a_lol_set: assert property (p_lol_set) else $error("loss of lock flag not set");
   property p_lol_sticky;
      ce && lol_flag_reg && !wr_fire |=> lol_flag_reg;
   endproperty
   a_lol_sticky: assert property (p_lol_sticky) else $error("loss flag dropped");
   property p_lol_clear;
      ce && wr_fire && wstrb0_reg && waddr_reg == OFF_STATUS && wdata_reg[LOL_BIT] &&
      !loss_pulse |=> !lol_flag_reg && !lol_irq;
   endproperty
   a_lol_clear: assert property (p_lol_clear) else $error("loss flag not cleared");
   property p_irq_hold;
      lol_irq == (lol_flag_reg && lol_ie_reg);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq not flag and enable");
   property p_bresp_time;
      ce && aw_full_reg && w_full_reg && !bvalid_reg |=> s_axi_bvalid or !ce;
   endproperty
   a_bresp_time: assert property (p_bresp_time) else $error("write response late");
endmodule
`default_nettype wire

/* File: dv/clgt_ctrl_tb_top.sv */
// testbench for the clock generator control slice: drives the AXI4-Lite port
// and the generator state inputs, judges every control output and every register readback except the source register
// assumes the design's package and module are compiled before this file
`default_nettype none
module clgt_ctrl_tb_top;
   import clgt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // signals
   // ****************************************
   logic aclk, aresetn, ce;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic lock_detect_en, loop_locked, stop_mode, bypass_mode, ext_ref_mode;
   logic [1:0] clock_source_select;
   logic [3:0] bus_div_factor;
   logic high_range, osc_high_gain, ext_ref_source_sel, loop_enable;
   logic ext_ref_clock_out_en, ext_ref_run, lol_irq;
   logic [8:0] irc_period_trim;
   int err_total = 0;
   int comparisons = 0;
   int cycle_count = 0;

   clgt_ctrl dut_u (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .lock_detect_en(lock_detect_en), .loop_locked(loop_locked), .stop_mode(stop_mode),
      .bypass_mode(bypass_mode), .ext_ref_mode(ext_ref_mode),
      .clock_source_select(clock_source_select), .bus_div_factor(bus_div_factor),
      .high_range(high_range), .osc_high_gain(osc_high_gain),
      .ext_ref_source_sel(ext_ref_source_sel), .loop_enable(loop_enable),
      .ext_ref_clock_out_en(ext_ref_clock_out_en), .ext_ref_run(ext_ref_run),
      .irc_period_trim(irc_period_trim), .lol_irq(lol_irq)
   );

   // ****************************************
   // clock, watchdog, common tasks
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycle_count++;
      if (cycle_count == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, 4'hF, r);
      check("write response", 32'(r), 32'(RESP_OKAY));
      idle(2);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      check("read data", d, {24'h000000, exp});
      check("read response", 32'(r), 32'(RESP_OKAY));
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_values();
      rd_chk(OFF_CTRL_TWO, CTRL_TWO_RST);
      rd_chk(OFF_TRIM, TRIM_RST);
      rd_chk(OFF_STATUS, 8'h00);
      rd_chk(OFF_LOOP_CTRL, 8'h00);
      check("bus divider", 32'(bus_div_factor), 32'h2);
      check("trim out", 32'(irc_period_trim), 32'h100);
      check("irq", 32'(lol_irq), 32'h0);
   endtask

   task automatic t_fields();
      logic [7:0] c;
      for (int i = 0; i < 4; i++) begin
         c = {i[1:0], i[0], i[1], 1'b0, i[0], 2'b00};
         wr(OFF_CTRL_TWO, c);
         rd_chk(OFF_CTRL_TWO, c);
         check("bus divider", 32'(bus_div_factor), 32'(4'h1 << i));
         check("range", 32'(high_range), 32'(i[0]));
         check("gain", 32'(osc_high_gain), 32'(i[1]));
         check("ref select", 32'(ext_ref_source_sel), 32'(i[0]));
      end
   endtask

   task automatic lp_case(input logic [7:0] c, input logic byp, input logic exp);
      wr(OFF_CTRL_TWO, c);
      bypass_mode <= byp;
      idle(3);
      check("loop enable", 32'(loop_enable), 32'(exp));
      bypass_mode <= 1'b0;
   endtask

   task automatic er_case(input logic [7:0] c, input logic pre, input logic en_s, input logic run_s);
      wr(OFF_CTRL_TWO, c);
      ext_ref_mode <= pre;
      idle(3);
      check("ref out enable", 32'(ext_ref_clock_out_en), 32'(c[1]));
      check("ref run", 32'(ext_ref_run), 32'(c[1] | pre));
      stop_mode <= 1'b1;
      ext_ref_mode <= 1'b0;
      idle(3);
      check("ref out enable stop", 32'(ext_ref_clock_out_en), 32'(en_s));
      check("ref run stop", 32'(ext_ref_run), 32'(run_s));
      stop_mode <= 1'b0;
      idle(2);
   endtask

   task automatic t_trim();
      logic [7:0] v [3] = '{8'h00, 8'hFF, 8'h55};
      foreach (v[i]) begin
         wr(OFF_TRIM, v[i]);
         rd_chk(OFF_TRIM, v[i]);
         check("trim out", 32'(irc_period_trim), 32'({v[i], 1'b0}));
      end
      wr(OFF_STATUS, 8'h01);
      check("trim out fine", 32'(irc_period_trim), 32'h0AB);
      wr(OFF_STATUS, 8'h00);
   endtask

   task automatic t_source();
      logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h2, SRC_LOOP};
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SRC_CTRL, {i[1:0], 6'h00});
         check("source select", 32'(clock_source_select), 32'(exp[i]));
      end
   endtask

   task automatic t_loss_of_lock();
      loop_locked <= 1'b1;
      idle(3);
      rd_chk(OFF_STATUS, 8'h40);
      loop_locked <= 1'b0;
      idle(4);
      rd_chk(OFF_STATUS, 8'h00);
      lock_detect_en <= 1'b1;
      loop_locked <= 1'b1;
      idle(3);
      loop_locked <= 1'b0;
      idle(4);
      rd_chk(OFF_STATUS, 8'h80);
      check("irq masked", 32'(lol_irq), 32'h0);
      wr(OFF_LOOP_CTRL, 8'h80);
      check("irq enabled", 32'(lol_irq), 32'h1);
      wr(OFF_STATUS, 8'h00);
      rd_chk(OFF_STATUS, 8'h80);
      check("irq held", 32'(lol_irq), 32'h1);
      lock_detect_en <= 1'b0;
      wr(OFF_STATUS, 8'h80);
      rd_chk(OFF_STATUS, 8'h00);
      check("irq dropped", 32'(lol_irq), 32'h0);
   endtask

   task automatic t_bad_access();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h20, 8'hFF, 4'hF, r);
      check("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
      axi_rd(8'h20, d, r);
      check("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
      check("unmapped read data", d, 32'h0);
      axi_wr(OFF_TRIM, 8'h11, 4'h0, r);
      check("no strobe resp", 32'(r), 32'(RESP_OKAY));
      rd_chk(OFF_TRIM, 8'h55);
   endtask

   task automatic t_freeze();
      ce <= 1'b0;
      ext_ref_mode <= 1'b1;
      idle(3);
      check("frozen ref run", 32'(ext_ref_run), 32'h0);
      ce <= 1'b1;
      idle(2);
      check("thawed ref run", 32'(ext_ref_run), 32'h1);
      ext_ref_mode <= 1'b0;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      aresetn <= 1'b0;
      ce <= 1'b1;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} <= '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
      {lock_detect_en, loop_locked, stop_mode, bypass_mode, ext_ref_mode} <= '0;
      idle(20);
      aresetn <= 1'b1;
      idle(3);
      t_reset_values();
      t_fields();
      lp_case(8'h48, 1'b1, 1'b0);
      lp_case(8'h48, 1'b0, 1'b1);
      lp_case(8'h40, 1'b1, 1'b1);
      er_case(8'h43, 1'b0, 1'b1, 1'b1);
      er_case(8'h42, 1'b0, 1'b0, 1'b0);
      er_case(8'h41, 1'b0, 1'b0, 1'b0);
      er_case(8'h41, 1'b1, 1'b0, 1'b1);
      t_trim();
      t_source();
      t_loss_of_lock();
      t_bad_access();
      t_freeze();
      give_verdict();
   end
endmodule
`default_nettype wire
